// file: pdsl_serial_load.sv
// three-wire serial loader of the reference, programmable and swallow ratios
//
// The register offsets and register access over APB were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "pdsl_regs.svh"

// Overview of operation
// - Frequency setting comes only over serial clock, serial data and latch strobe.
// - Ratio data arrives serially into a shift register, one bit per clock.
// - Strobe copies shift register into the counter its word selects; here only while the lock bit of the control register is clear.
// - Bit 0 is destination: 1 means reference, 0 means program/swallow counters.
// - Reference word holds 14-bit reference ratio above bit 0, valid 8 to 16383.
// - Reference word top bit picks prescaler: 0 gives 128/129, 1 gives 64/65.
// - Counter word holds 7-bit swallow ratio just above bit 0, 0 to 127.
// - Counter word holds 11-bit programmable ratio at the top, 3 to 2047.
// - Output frequency equals (m*n + a) times source frequency over r.
// - Strobe rising after a counter word switches to the new ratio.
module pdsl_serial_load
	import pdsl_pkg::*;
(
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// apb slave
	input  wire logic [7:0]  paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// serial pins from the host
	input  wire logic        host_serial_clock_pin,
	input  wire logic        host_serial_data_pin,
	input  wire logic        host_strobe_pin,
	// divider chain
	input  wire logic        vco_in,
	output logic             ref_pulse,
	output logic             fb_pulse,
	output logic             prescaler_modulus_select
);

	// pin synchronisers: stage 1 feeds stage 2 only, stage 3 is for edges
	logic [2:0]                  sclk_sync_ff;
	logic [1:0]                  sdat_sync_ff;
	logic [2:0]                  strb_sync_ff;
	logic [2:0]                  vco_sync_ff;
	logic                        sclk_rise;
	logic                        latch_strobe;
	logic                        vco_ce;

	// ------------------------------------------------------------
	// input synchronisers and edge detection
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			sclk_sync_ff <= '0;
			sdat_sync_ff <= '0;
			strb_sync_ff <= '0;
			vco_sync_ff  <= '0;
		end
		else
		begin
			sclk_sync_ff <= {sclk_sync_ff[1:0], host_serial_clock_pin};
			sdat_sync_ff <= {sdat_sync_ff[0], host_serial_data_pin};
			strb_sync_ff <= {strb_sync_ff[1:0], host_strobe_pin};
			vco_sync_ff  <= {vco_sync_ff[1:0], vco_in};
		end
	end

	// data and clock share the same delay, so data held by the host lines up
	assign sclk_rise    = sclk_sync_ff[1] & ~sclk_sync_ff[2];
	assign latch_strobe = strb_sync_ff[1] & ~strb_sync_ff[2];
	assign vco_ce       = vco_sync_ff[1] & ~vco_sync_ff[2];

	// ------------------------------------------------------------
	// shift register and ratio latches
	// ------------------------------------------------------------
	logic [`PDSL_SR_W-1:0]   sr_ff;
	logic [`PDSL_SR_W-1:0]   nxt_sr;
	logic [4:0]              bitcnt_ff;
	logic [4:0]              nxt_bitcnt;
	logic [7:0]              ldcnt_ff;
	logic [7:0]              nxt_ldcnt;
	logic [`PDSL_REF_W-1:0]  ref_ff;
	logic [`PDSL_REF_W-1:0]  nxt_ref;
	logic [`PDSL_PROG_W-1:0] prog_ff;
	logic [`PDSL_PROG_W-1:0] nxt_prog;
	logic [`PDSL_SWAL_W-1:0] swal_ff;
	logic [`PDSL_SWAL_W-1:0] nxt_swal;
	pdsl_mod_t               mod_ff;
	pdsl_mod_t               nxt_mod;
	logic [1:0]              ctrl_ff;
	logic [1:0]              nxt_ctrl;
	logic                    load_ok;

	assign load_ok = latch_strobe & ~ctrl_ff[`PDSL_CTRL_LOCK];

	// shift on clock rise, route the word on strobe rise
	always_comb
	begin
		nxt_sr     = sr_ff;
		nxt_bitcnt = bitcnt_ff;
		nxt_ldcnt  = ldcnt_ff;
		nxt_ref    = ref_ff;
		nxt_prog   = prog_ff;
		nxt_swal   = swal_ff;
		nxt_mod    = mod_ff;
		if (sclk_rise)
		begin
			nxt_sr = {sr_ff[`PDSL_SR_W-2:0], sdat_sync_ff[1]};
			if (bitcnt_ff != 5'h1F)
				nxt_bitcnt = bitcnt_ff + 5'h01;
		end
		if (load_ok)
		begin
			nxt_bitcnt = '0;
			nxt_ldcnt  = ldcnt_ff + 8'h01;
			if (pdsl_dest_t'(sr_ff[`PDSL_WORD_DEST]) == PDSL_DEST_REF)
			begin
				nxt_ref = sr_ff[`PDSL_REF_MSB:`PDSL_REF_LSB];
				nxt_mod = pdsl_mod_t'(sr_ff[`PDSL_MOD_POS]);
			end
			else
			begin
				nxt_swal = sr_ff[`PDSL_SWAL_MSB:`PDSL_SWAL_LSB];
				nxt_prog = sr_ff[`PDSL_PROG_MSB:`PDSL_PROG_LSB];
			end
		end
	end

	// loader registers
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			sr_ff     <= '0;
			bitcnt_ff <= '0;
			ldcnt_ff  <= '0;
			ref_ff    <= `PDSL_REF_RST;
			prog_ff   <= `PDSL_PROG_RST;
			swal_ff   <= `PDSL_SWAL_RST;
			mod_ff    <= PDSL_MOD_128;
		end
		else
		begin
			sr_ff     <= nxt_sr;
			bitcnt_ff <= nxt_bitcnt;
			ldcnt_ff  <= nxt_ldcnt;
			ref_ff    <= nxt_ref;
			prog_ff   <= nxt_prog;
			swal_ff   <= nxt_swal;
			mod_ff    <= nxt_mod;
		end
	end

	assign prescaler_modulus_select = mod_ff;

	// ------------------------------------------------------------
	// reference divider: pclk stands in for the source frequency
	// ------------------------------------------------------------
	logic [`PDSL_REF_W-1:0] rcnt_ff;
	logic [`PDSL_REF_W-1:0] nxt_rcnt;
	logic                   rpulse_ff;
	logic                   nxt_rpulse;

	// a ratio below 8 is outside the valid range; counter wraps at r, or at 16384 when r is 0
	always_comb
	begin
		nxt_rcnt   = '0;
		nxt_rpulse = 1'b0;
		if (ctrl_ff[`PDSL_CTRL_DIV_EN])
		begin
			if (rcnt_ff >= ref_ff - 14'h0001)
				nxt_rpulse = 1'b1;
			else
				nxt_rcnt = rcnt_ff + 14'h0001;
		end
	end

	// reference divider registers
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			rcnt_ff   <= '0;
			rpulse_ff <= 1'b0;
		end
		else
		begin
			rcnt_ff   <= nxt_rcnt;
			rpulse_ff <= nxt_rpulse;
		end
	end

	assign ref_pulse = rpulse_ff;

	// feedback divider on synchronised oscillator edges
	pdsl_swallow_div u_fb_div
	(
		.pclk          (pclk),
		.presetn       (presetn),
		.div_en        (ctrl_ff[`PDSL_CTRL_DIV_EN]),
		.vco_ce        (vco_ce),
		.modsel        (mod_ff),
		.prog_ratio    (prog_ff),
		.swallow_ratio (swal_ff),
		.fb_pulse      (fb_pulse)
	);

	// ------------------------------------------------------------
	// apb slave: zero wait states, read data captured in setup
	// ------------------------------------------------------------
	logic [31:0] rdata_ff;
	logic [31:0] nxt_rdata;
	logic        addr_hit;

	assign addr_hit = (paddr == `PDSL_OFS_CTRL) || (paddr == `PDSL_OFS_REF) ||
	                  (paddr == `PDSL_OFS_CNT)  || (paddr == `PDSL_OFS_SHIFT);
	assign pready   = 1'b1;
	assign pslverr  = psel & penable & ~addr_hit;

	// control write and read mux; writes to status words are ignored
	always_comb
	begin
		nxt_ctrl  = ctrl_ff;
		nxt_rdata = rdata_ff;
		if (psel & penable & pwrite & (paddr == `PDSL_OFS_CTRL))
			nxt_ctrl = pwdata[1:0];
		if (psel & ~penable)
		begin
			nxt_rdata = '0;
			unique case (paddr)
				`PDSL_OFS_CTRL:
					nxt_rdata[1:0] = ctrl_ff;
				`PDSL_OFS_REF:
				begin
					nxt_rdata[`PDSL_REF_W-1:0]  = ref_ff;
					nxt_rdata[`PDSL_REF_MOD_BIT] = mod_ff;
				end
				`PDSL_OFS_CNT:
				begin
					nxt_rdata[`PDSL_SWAL_W-1:0] = swal_ff;
					nxt_rdata[`PDSL_CNT_PROG_LSB +: `PDSL_PROG_W] = prog_ff;
				end
				`PDSL_OFS_SHIFT:
				begin
					nxt_rdata[`PDSL_SR_W-1:0] = sr_ff;
					nxt_rdata[`PDSL_SHIFT_CNT_LSB +: 5] = bitcnt_ff;
					nxt_rdata[`PDSL_SHIFT_LD_LSB +: 8]  = ldcnt_ff;
				end
				default:
					nxt_rdata = '0;
			endcase
		end
	end

	// bus registers
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctrl_ff  <= `PDSL_CTRL_RST;
			rdata_ff <= '0;
		end
		else
		begin
			ctrl_ff  <= nxt_ctrl;
			rdata_ff <= nxt_rdata;
		end
	end

	assign prdata = rdata_ff;

endmodule // pdsl_serial_load

`default_nettype wire

// file: pdsl_regs.svh
// offsets, field positions, reset values and sizes of the serial divider loader
`ifndef PDSL_REGS_SVH
`define PDSL_REGS_SVH

// ----------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------
`define PDSL_OFS_CTRL      8'h00
`define PDSL_OFS_REF       8'h04
`define PDSL_OFS_CNT       8'h08
`define PDSL_OFS_SHIFT     8'h0C

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define PDSL_CTRL_DIV_EN   0
`define PDSL_CTRL_LOCK     1
`define PDSL_REF_MOD_BIT   16
`define PDSL_CNT_PROG_LSB  8
`define PDSL_SHIFT_CNT_LSB 16
`define PDSL_SHIFT_LD_LSB  24

// serial word layout: destination at bit 0, fields above it
`define PDSL_WORD_DEST     0
`define PDSL_REF_LSB       1
`define PDSL_REF_MSB       14
`define PDSL_MOD_POS       15
`define PDSL_SWAL_LSB      1
`define PDSL_SWAL_MSB      7
`define PDSL_PROG_LSB      8
`define PDSL_PROG_MSB      18

// ----------------------------------------------------------------
// sizes and reset values
// ----------------------------------------------------------------
`define PDSL_SR_W          19
`define PDSL_REF_W         14
`define PDSL_SWAL_W        7
`define PDSL_PROG_W        11
`define PDSL_PRE_W         8
`define PDSL_REF_RST       14'h0008
`define PDSL_PROG_RST      11'h003
`define PDSL_SWAL_RST      7'h00
`define PDSL_CTRL_RST      2'h1
// last prescaler count while swallowing: modulus plus one events per cycle
`define PDSL_MOD_HI        8'h40
`define PDSL_MOD_LO        8'h80

`endif

// file: pdsl_pkg.sv
// types shared by the serial divider loader
`default_nettype none
package pdsl_pkg;

	// destination carried in bit 0 of each serial word
	typedef enum logic
	{
		PDSL_DEST_CNT = 1'b0,
		PDSL_DEST_REF = 1'b1
	} pdsl_dest_t;

	// dual-modulus prescaler choice
	typedef enum logic
	{
		PDSL_MOD_128 = 1'b0,
		PDSL_MOD_64  = 1'b1
	} pdsl_mod_t;

endpackage

`default_nettype wire

// file: pdsl_swallow_div.sv
// pulse-swallow feedback divider: one output pulse per (m*n + a) input events
`timescale 1ns/10ps
`default_nettype none
`include "pdsl_regs.svh"

module pdsl_swallow_div
	import pdsl_pkg::*;
(
	// clock and reset
	input  wire logic                    pclk,
	input  wire logic                    presetn,
	// control
	input  wire logic                    div_en,
	input  wire logic                    vco_ce,
	input  wire pdsl_mod_t               modsel,
	input  wire logic [`PDSL_PROG_W-1:0] prog_ratio,
	input  wire logic [`PDSL_SWAL_W-1:0] swallow_ratio,
	// result
	output logic                         fb_pulse
);

	logic [`PDSL_PRE_W-1:0]  pcnt_ff;
	logic [`PDSL_PRE_W-1:0]  nxt_pcnt;
	logic [`PDSL_PROG_W-1:0] ncnt_ff;
	logic [`PDSL_PROG_W-1:0] nxt_ncnt;
	logic [`PDSL_SWAL_W-1:0] acnt_ff;
	logic [`PDSL_SWAL_W-1:0] nxt_acnt;
	logic                    fb_ff;
	logic                    nxt_fb;
	logic [`PDSL_PRE_W-1:0]  pre_last;
	logic                    swallowing;

	// ------------------------------------------------------------
	// prescaler, programmable and swallow counters
	// ------------------------------------------------------------
	// ratios are read live, so a freshly latched word takes effect at once
	always_comb
	begin
		swallowing = (acnt_ff < swallow_ratio);
		// m+1 while swallowing, m afterwards: total is m*n + a
		pre_last   = (modsel == PDSL_MOD_64) ? `PDSL_MOD_HI : `PDSL_MOD_LO;
		if (!swallowing)
			pre_last = pre_last - 8'h01;
		nxt_pcnt = pcnt_ff;
		nxt_ncnt = ncnt_ff;
		nxt_acnt = acnt_ff;
		nxt_fb   = 1'b0;
		if (!div_en)
		begin
			nxt_pcnt = '0;
			nxt_ncnt = '0;
			nxt_acnt = '0;
		end
		else if (vco_ce)
		begin
			if (pcnt_ff >= pre_last)
			begin
				nxt_pcnt = '0;
				if (swallowing)
					nxt_acnt = acnt_ff + 7'h01;
				if (ncnt_ff >= prog_ratio - 11'h001)
				begin
					// end of cycle relies on n > a from the host
					nxt_ncnt = '0;
					nxt_acnt = '0;
					nxt_fb   = 1'b1;
				end
				else
					nxt_ncnt = ncnt_ff + 11'h001;
			end
			else
				nxt_pcnt = pcnt_ff + 8'h01;
		end
	end

	// counter registers
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pcnt_ff <= '0;
			ncnt_ff <= '0;
			acnt_ff <= '0;
			fb_ff   <= 1'b0;
		end
		else
		begin
			pcnt_ff <= nxt_pcnt;
			ncnt_ff <= nxt_ncnt;
			acnt_ff <= nxt_acnt;
			fb_ff   <= nxt_fb;
		end
	end

	assign fb_pulse = fb_ff;

endmodule // pdsl_swallow_div

`default_nettype wire

// file: pdsl_serial_load_chk.sv
// assertion checker for the serial divider loader, bound to its top module
`timescale 1ns/10ps
`default_nettype none
`include "pdsl_regs.svh"

module pdsl_serial_load_chk
(
	// clock and reset
	input wire logic        pclk,
	input wire logic        presetn,
	// apb requests
	input wire logic [7:0]  paddr,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [31:0] pwdata,
	// serial pins and divider chain
	input wire logic        host_serial_clock_pin,
	input wire logic        host_serial_data_pin,
	input wire logic        host_strobe_pin,
	input wire logic        vco_in,
	input wire logic        ref_pulse,
	input wire logic        fb_pulse,
	input wire logic        prescaler_modulus_select
);
	// ----------------------------------------------------------------
	// shadow of the shifted bits, control bits and event ages
	// ----------------------------------------------------------------
	logic [18:0] sr_ff;
	logic        lock_ff, en_ff, sclk_ff, strb_ff, vco_ff;
	logic [3:0]  strb_age_ff, vco_age_ff;

	// ages saturate so that they never wrap into a false match
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			sr_ff       <= '0;
			{lock_ff, en_ff, sclk_ff, strb_ff, vco_ff} <= 5'h08;
			strb_age_ff <= 4'hF;
			vco_age_ff  <= 4'hF;
		end
		else
		begin
			sclk_ff     <= host_serial_clock_pin;
			strb_ff     <= host_strobe_pin;
			vco_ff      <= vco_in;
			if (host_serial_clock_pin && !sclk_ff)
				sr_ff <= {sr_ff[17:0], host_serial_data_pin};
			if (psel && penable && pwrite && paddr == `PDSL_OFS_CTRL)
				{lock_ff, en_ff} <= pwdata[1:0];
			strb_age_ff <= (host_strobe_pin && !strb_ff) ? 4'h0 : strb_age_ff + {3'h0, strb_age_ff != 4'hF};
			vco_age_ff  <= (vco_in && !vco_ff) ? 4'h0 : vco_age_ff + {3'h0, vco_age_ff != 4'hF};
		end
	end

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	// ----------------------------------------------------------------
	// properties
	// ----------------------------------------------------------------
	property p_mod_load; $rose(host_strobe_pin) && sr_ff[0] && !lock_ff |-> ##3 prescaler_modulus_select == sr_ff[15]; endproperty
	a_mod_load: assert property (p_mod_load) else $error("prescaler select not loaded");
	property p_cnt_keeps; $rose(host_strobe_pin) && !sr_ff[0] |=> $stable(prescaler_modulus_select) [*5]; endproperty
	a_cnt_keeps: assert property (p_cnt_keeps) else $error("counter word moved select");
	property p_lock_keeps; $rose(host_strobe_pin) && lock_ff |=> $stable(prescaler_modulus_select) [*5]; endproperty
	a_lock_keeps: assert property (p_lock_keeps) else $error("locked strobe moved select");
	property p_mod_quiet; $changed(prescaler_modulus_select) |-> strb_age_ff >= 4'h1 && strb_age_ff <= 4'h3; endproperty
	a_mod_quiet: assert property (p_mod_quiet) else $error("select changed without strobe");
	property p_ref_gap; ref_pulse |=> !ref_pulse [*7]; endproperty
	a_ref_gap: assert property (p_ref_gap) else $error("reference pulses too close");
	property p_fb_gap; fb_pulse |=> !fb_pulse [*3]; endproperty
	a_fb_gap: assert property (p_fb_gap) else $error("feedback pulses too close");
	property p_fb_cause; fb_pulse |-> vco_age_ff <= 4'h6; endproperty
	a_fb_cause: assert property (p_fb_cause) else $error("feedback pulse without oscillator edge");
	property p_quiet_off; !en_ff && !$past(en_ff) && !$past(en_ff, 2) |-> !ref_pulse && !fb_pulse; endproperty
	a_quiet_off: assert property (p_quiet_off) else $error("pulse while divider off");
endmodule // pdsl_serial_load_chk
`default_nettype wire

// file: pdsl_host_model.sv
// behavioural host that shifts words into the loader and pulses the strobe
`timescale 1ns/10ps
`default_nettype none

module pdsl_host_model
(
	// clock
	input  wire logic pclk,
	// serial pins toward the loader
	output var logic  host_serial_clock_pin,
	output var logic  host_serial_data_pin,
	output var logic  host_strobe_pin
);
	// ----------------------------------------------------------------
	// idle lines, then word and strobe tasks
	// ----------------------------------------------------------------
	initial
	begin
		host_serial_clock_pin = 1'b0;
		host_serial_data_pin  = 1'b0;
		host_strobe_pin       = 1'b0;
	end

	// three edges per phase keeps each level above the two-cycle minimum
	task automatic send_word(input logic [18:0] w, input logic [4:0] nb);
		for (int i = nb - 1; i >= 0; i--)
		begin
			host_serial_data_pin <= w[i];
			repeat (3) @(posedge pclk);
			host_serial_clock_pin <= 1'b1;
			repeat (3) @(posedge pclk);
			host_serial_clock_pin <= 1'b0;
			repeat (3) @(posedge pclk);
			host_serial_data_pin <= ~w[i]; // bit no longer held
			@(posedge pclk);
		end
	endtask

	// strobe only after the last clock fall, so it never meets a clock rise
	task automatic pulse_strobe;
		host_strobe_pin <= 1'b1;
		repeat (3) @(posedge pclk);
		host_strobe_pin <= 1'b0;
		repeat (3) @(posedge pclk);
	endtask
endmodule // pdsl_host_model
`default_nettype wire

// file: pdsl_serial_load_tb.sv
// self-checking testbench of the serial divider loader
`timescale 1ns/10ps
`default_nettype none
`include "pdsl_regs.svh"

module pdsl_serial_load_tb;
	typedef struct { logic [18:0] word; logic [4:0] nb; logic [7:0] addr; logic [31:0] exp; logic pms; } pdsl_row_t;

	// ----------------------------------------------------------------
	// signals, table and instances
	// ----------------------------------------------------------------
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, vco_in;
	logic        sclk, sdata, strobe, ref_pulse, fb_pulse, pms, err;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, d;
	logic [15:0] n;
	int          err_total, checks;
	// host keeps n above a; words are ratio fields split from the target divide
	pdsl_row_t   rows [4] = '{
		'{19'h07FFF, 5'h10, `PDSL_OFS_REF, 32'h0000_3FFF, 1'b0},
		'{19'h7FFFE, 5'h13, `PDSL_OFS_CNT, 32'h0007_FF7F, 1'b0},
		'{19'h08011, 5'h10, `PDSL_OFS_REF, 32'h0001_0008, 1'b1},
		'{19'h00304, 5'h13, `PDSL_OFS_CNT, 32'h0000_0302, 1'b1}};

	pdsl_serial_load i_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.host_serial_clock_pin(sclk), .host_serial_data_pin(sdata), .host_strobe_pin(strobe), .vco_in(vco_in),
		.ref_pulse(ref_pulse), .fb_pulse(fb_pulse), .prescaler_modulus_select(pms));
	pdsl_host_model i_host (.pclk(pclk), .host_serial_clock_pin(sclk), .host_serial_data_pin(sdata),
		.host_strobe_pin(strobe));

	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp)
		begin
			err_total++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// one apb transfer, released after the edge that samples pready
	task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] wd);
		psel <= 1'b1;
		paddr <= a;
		pwrite <= w;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		d = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	// cycles between two successive pulses of the chosen output
	task automatic gap(input logic sel);
		repeat (2)
		begin
			n = 16'h0000;
			do
			begin
				@(negedge pclk);
				n++;
			end
			while ((sel ? fb_pulse : ref_pulse) !== 1'b1 && n < 16'h1000);
		end
	endtask

	task automatic end_of_test;
		$display("checks=%0d err_total=%0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// clock, oscillator, watchdog and main sequence
	// ----------------------------------------------------------------
	initial
	begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end

	// oscillator rises six cycles apart, slow enough for the synchroniser
	initial
	begin
		vco_in = 1'b0;
		forever
		begin
			repeat (3) @(posedge pclk);
			vco_in <= ~vco_in;
		end
	end

	initial
	begin
		#200000;
		err_total++;
		end_of_test();
	end

	initial
	begin
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		repeat (3) @(posedge pclk);
		foreach (rows[i])
		begin
			i_host.send_word(rows[i].word, rows[i].nb);
			i_host.pulse_strobe();
			apb(rows[i].addr, 1'b0, 32'h0);
			chk(d, rows[i].exp);
			chk({31'h0, pms}, {31'h0, rows[i].pms});
		end
		gap(1'b0);
		chk({16'h0, n}, 32'h0000_0008);
		gap(1'b1);
		chk({16'h0, n}, 32'h0000_048C);
		apb(`PDSL_OFS_CTRL, 1'b1, 32'h0);
		apb(`PDSL_OFS_CTRL, 1'b0, 32'h0);
		chk(d, 32'h0);
		apb(`PDSL_OFS_CTRL, 1'b1, 32'h1);
		// shifting alone leaves every active ratio in place
		i_host.send_word(19'h5A5A5, 5'h13);
		apb(`PDSL_OFS_SHIFT, 1'b0, 32'h0);
		chk({16'h0, d[15:0]}, 32'h0000_A5A5);
		chk({24'h0, d[31:24]}, 32'h0000_0004);
		chk({27'h0, d[20:16]}, 32'h0000_0013);
		apb(`PDSL_OFS_CNT, 1'b0, 32'h0);
		chk(d, 32'h0000_0302);
		chk({31'h0, pms}, 32'h1);
		// a locked strobe is ignored, the next one loads the same bits
		apb(`PDSL_OFS_CTRL, 1'b1, 32'h3);
		i_host.pulse_strobe();
		apb(`PDSL_OFS_REF, 1'b0, 32'h0);
		chk(d, 32'h0001_0008);
		apb(`PDSL_OFS_CTRL, 1'b1, 32'h1);
		i_host.pulse_strobe();
		apb(`PDSL_OFS_REF, 1'b1, 32'h0);
		apb(`PDSL_OFS_REF, 1'b0, 32'h0);
		chk(d, 32'h0001_12D2);
		apb(8'h10, 1'b0, 32'h0);
		chk({d[30:0], err}, 32'h1);
		// second reset in mid-run restores the default ratios
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		repeat (3) @(posedge pclk);
		apb(`PDSL_OFS_REF, 1'b0, 32'h0);
		chk(d, 32'h0000_0008);
		apb(`PDSL_OFS_CNT, 1'b0, 32'h0);
		chk(d, 32'h0000_0300);
		chk({31'h0, pms}, 32'h0);
		// default ratios in the 128/129 mode: 3*128 oscillator rises of six cycles
		gap(1'b1);
		chk({16'h0, n}, 32'h0000_0900);
		end_of_test();
	end
endmodule // pdsl_serial_load_tb

bind pdsl_serial_load pdsl_serial_load_chk i_chk (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
	.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .host_serial_clock_pin(host_serial_clock_pin),
	.host_serial_data_pin(host_serial_data_pin), .host_strobe_pin(host_strobe_pin), .vco_in(vco_in),
	.ref_pulse(ref_pulse), .fb_pulse(fb_pulse), .prescaler_modulus_select(prescaler_modulus_select));
`default_nettype wire
